// *** spwm_core.sv ***
// Scrambled PWM sixteen-channel sink driver core with global current scale.
// Assumes host pins are asynchronous to clk_sys and the analog sink stage
// multiplies the full-scale current by global_current_scale / 127.
//
// How it works
// - One current scale code drives all sixteen sinks together.
// - Current scale has 128 steps, zero to full-scale current.
// - Sink current is full scale times code over 127; 7Fh is full.
// - Scale and duty codes arrive only through the serial port.
// - Scale shift register and both scale latches have no reset value.
// - One display cycle is split into 128 equal segments.
// - Cycle runs from first clock edge after unblank to edge 65536.
// - Each segment spans at most 512 gray step clock periods.
// - Each output's on time comes from its own 16-bit duty code.
// - Code 1 gives one period in first segment; code 0 never.
// - Extra counts go to segments in 7-bit bit-reversed order.
// - Code 128 gives one period in each of the 128 segments.
module spwm_core
    import spwm_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    // Host pins
    input  wire spwm_serial_s        serial_in,
    input  wire logic                gray_step_clock,
    input  wire logic                blank,
    // Analog stage
    output logic [NUM_CH-1:0]        sink_output_n,
    output logic [SCALE_W-1:0]       global_current_scale
);

    // Seven-bit bit reversal of a segment index
    function automatic logic [SEG_W-1:0] seg_rank(input logic [SEG_W-1:0] seg);
        logic [SEG_W-1:0] r;
        r = '0;
        for (int i = 0; i < SEG_W; i++) begin
            r[i] = seg[SEG_W-1-i];
        end
        return r;
    endfunction

    // On/off decision for one duty code at one cycle count
    function automatic logic duty_on(input logic [DUTY_W-1:0] code, input logic [DUTY_W-1:0] cnt);
        logic [POS_W-1:0] base;
        logic [SEG_W-1:0] extra;
        logic [POS_W-1:0] pos;
        logic [SEG_W-1:0] seg;
        base  = code[DUTY_W-1:SEG_W];
        extra = code[SEG_W-1:0];
        pos   = cnt[POS_W-1:0];
        seg   = cnt[DUTY_W-1:POS_W];
        return (pos < base) || ((pos == base) && (seg_rank(seg) < extra));
    endfunction

    // Reset release through two flip-flops
    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Pin synchronisers and edge history
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic [PIN_W-1:0] pin_prev;
    assign pin_raw = {blank, gray_step_clock, serial_in.bc_sel, serial_in.latch,
                      serial_in.sclk, serial_in.sdata};
    always_ff @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
            pin_prev <= PIN_RESET;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edge strobes and blanking level from the synchronised pins
    logic sclk_rise;
    logic latch_rise;
    logic gclk_rise;
    logic blank_s;
    assign sclk_rise  = pin_sync[PB_SCLK] & ~pin_prev[PB_SCLK];
    assign latch_rise = pin_sync[PB_LATCH] & ~pin_prev[PB_LATCH];
    assign gclk_rise  = pin_sync[PB_GCLK] & ~pin_prev[PB_GCLK];
    assign blank_s    = pin_sync[PB_BLANK];

    // Serial data store: shift register, duty latch, two scale latches
    logic [SREG_W-1:0]  sreg;
    logic [SREG_W-1:0]  next_sreg;
    logic [DUTY_W-1:0]  duty [NUM_CH];
    logic [DUTY_W-1:0]  next_duty [NUM_CH];
    logic [SCALE_W-1:0] scale_l1;
    logic [SCALE_W-1:0] next_scale_l1;
    logic [SCALE_W-1:0] scale_l2;
    logic [SCALE_W-1:0] next_scale_l2;

    // Next values of the serial data store
    always_comb begin
        next_sreg     = sreg;
        next_duty     = duty;
        next_scale_l1 = scale_l1;
        next_scale_l2 = scale_l2;
        if (sclk_rise) begin
            next_sreg = {sreg[SREG_W-2:0], pin_sync[PB_SDATA]};
        end
        if (latch_rise && pin_sync[PB_BCSEL]) begin
            next_scale_l1 = sreg[SCALE_W-1:0];
        end else if (latch_rise) begin
            for (int n = 0; n < NUM_CH; n++) begin
                next_duty[n] = sreg[n*DUTY_W +: DUTY_W];
            end
        end
        // Second latch takes the first while outputs are blanked
        if (blank_s) begin
            next_scale_l2 = scale_l1;
        end
    end

    always_ff @(posedge clk_sys) begin
        sreg     <= next_sreg;
        duty     <= next_duty;
        scale_l1 <= next_scale_l1;
        scale_l2 <= next_scale_l2;
    end

    // code over 127 in analog stage
    assign global_current_scale = scale_l2;

    // Marks that a scale code has been latched since reset, so checks skip unloaded latches
    logic scale_seen;
    logic next_scale_seen;
    assign next_scale_seen = scale_seen | (latch_rise & pin_sync[PB_BCSEL]);
    always_ff @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            scale_seen <= 1'b0;
        end else begin
            scale_seen <= next_scale_seen;
        end
    end

    // Display-cycle counter
    spwm_count_s cyc;
    spwm_count_s next_cyc;
    always_comb begin
        next_cyc = cyc;
        if (blank_s) begin
            next_cyc.running = 1'b0;
            next_cyc.cnt     = CYCLE_FIRST;
        end else if (gclk_rise) begin
            if (!cyc.running || cyc.cnt == CYCLE_LAST) begin
                next_cyc.running = 1'b1;
                next_cyc.cnt     = CYCLE_FIRST;
            end else begin
                next_cyc.cnt = cyc.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            cyc <= '0;
        end else begin
            cyc <= next_cyc;
        end
    end

    // Sink decisions, refreshed at every gray step edge
    logic [NUM_CH-1:0] next_sink;
    always_comb begin
        next_sink = sink_output_n;
        if (blank_s) begin
            next_sink = '0;
        end else if (gclk_rise) begin
            for (int n = 0; n < NUM_CH; n++) begin
                next_sink[n] = duty_on(duty[n], next_cyc.cnt);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            sink_output_n <= '0;
        end else begin
            sink_output_n <= next_sink;
        end
    end

    // Checks
    logic edge_run;
    assign edge_run = gclk_rise && !blank_s;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync);

    sequence s_unblank_edge;
        !cyc.running && edge_run;
    endsequence

    sequence s_last_edge;
        cyc.running && cyc.cnt == CYCLE_LAST && edge_run;
    endsequence

    a_scale_shared: assert property (blank_s && scale_seen |=> global_current_scale == $past(scale_l1))
        else $error("scale output did not follow first latch while blanked");
    a_scale_hold_run: assert property (!blank_s && !$past(blank_s) |-> $stable(global_current_scale))
        else $error("scale changed while outputs enabled");
    a_cycle_start: assert property (s_unblank_edge |=> cyc.running && cyc.cnt == CYCLE_FIRST)
        else $error("cycle did not start at zero");
    a_cycle_wrap: assert property (s_last_edge |=> cyc.cnt == CYCLE_FIRST)
        else $error("cycle did not wrap after last edge");
    a_segment_step: assert property (cyc.running && $past(cyc.running) && $changed(cyc.cnt[15:9])
                                     |-> cyc.cnt[8:0] == 9'h000)
        else $error("segment changed mid-segment");
    a_blank_off: assert property (blank_s |=> sink_output_n == '0)
        else $error("sink on while blanked");
    a_code_zero: assert property (edge_run && duty[0] == 16'h0000 |=> !sink_output_n[0])
        else $error("code zero turned sink on");
    a_code_one: assert property (edge_run && duty[1] == 16'h0001
                                 |=> sink_output_n[1] == (cyc.cnt == 16'h0000))
        else $error("code one on at wrong count");
    a_code_two: assert property (edge_run && duty[2] == 16'h0002
                                 |=> sink_output_n[2] == (cyc.cnt == 16'h0000 || cyc.cnt == 16'h8000))
        else $error("code two on at wrong count");
    a_code_128: assert property (edge_run && duty[4] == 16'h0080
                                 |=> sink_output_n[4] == (cyc.cnt[8:0] == 9'h000))
        else $error("code 128 not once per segment");
    a_duty_match: assert property (edge_run && !latch_rise
                                   |=> sink_output_n[12] == ((cyc.cnt[8:0] < duty[12][15:7])
                                       || ((cyc.cnt[8:0] == duty[12][15:7])
                                       && ({cyc.cnt[9], cyc.cnt[10], cyc.cnt[11], cyc.cnt[12],
                                            cyc.cnt[13], cyc.cnt[14], cyc.cnt[15]} < duty[12][6:0]))))
        else $error("channel twelve decision mismatch");
    a_sink_hold: assert property (!gclk_rise && !blank_s |=> $stable(sink_output_n))
        else $error("sink changed between gray step edges");

endmodule

// *** spwm_core_tb_top.sv ***
// Self-checking bench for the scrambled PWM core.
// Assumes the host model drives all host pins; expectations come from the on rule.
module spwm_core_tb_top
    import spwm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic                clk_sys;
    logic                rstn;
    spwm_serial_s        serial_in;
    logic                gray_step_clock;
    logic                blank;
    logic [NUM_CH-1:0]   sink_output_n;
    logic [SCALE_W-1:0]  global_current_scale;
    int                  n_mismatch = 0;
    int                  compares = 0;
    int                  cyc = 0;
    localparam logic [15:0] CODES [NUM_CH] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
        16'h0080, 16'h007F, 16'h0081, 16'h00C1, 16'hFFFF, 16'h0200, 16'h0041, 16'h0040,
        16'h1234, 16'h8000, 16'h01FF, 16'h0100};

    // Clock and watchdog
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 50000) begin
            n_mismatch++;
            final_report();
        end
    end

    spwm_host_model u_spwm_host_model (.clk_sys(clk_sys), .serial_in(serial_in),
        .gray_step_clock(gray_step_clock), .blank(blank));
    spwm_core u_spwm_core (.clk_sys(clk_sys), .rstn(rstn), .serial_in(serial_in),
        .gray_step_clock(gray_step_clock), .blank(blank), .sink_output_n(sink_output_n),
        .global_current_scale(global_current_scale));

    // Expected sink level at a display count
    function automatic logic exp_on(input logic [15:0] code, input logic [15:0] cnt);
        logic [6:0] rev;
        for (int b = 0; b < 7; b++) rev[b] = cnt[15-b];
        return (cnt[8:0] < code[15:7]) || (cnt[8:0] == code[15:7] && rev < code[6:0]);
    endfunction

    // Compare sink vectors
    task automatic check_sinks(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t sinks got %h exp %h", $time, got, exp);
        end
    endtask

    // Compare scale codes
    task automatic check_scale(input logic [6:0] got, input logic [6:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t scale got %h exp %h", $time, got, exp);
        end
    endtask

    // Step through counts and compare every channel
    task automatic run_counts(input int first, input int last);
        logic [15:0] exp;
        for (int c = first; c <= last; c++) begin
            u_spwm_host_model.step();
            for (int n = 0; n < NUM_CH; n++) exp[n] = exp_on(CODES[n], c[15:0]);
            check_sinks(sink_output_n, exp);
        end
    endtask

    // Scale codes at both ends, and no change while unblanked
    task automatic sc_scale();
        logic [6:0] vals [3] = '{7'h00, 7'h01, SCALE_FULL};
        foreach (vals[i]) begin
            u_spwm_host_model.load_scale(vals[i]);
            check_scale(global_current_scale, vals[i]);
        end
        u_spwm_host_model.set_blank(1'b0);
        u_spwm_host_model.shift({249'h0, 7'h2A}, 7);
        u_spwm_host_model.latch(1'b1);
        check_scale(global_current_scale, SCALE_FULL);
        u_spwm_host_model.set_blank(1'b1);
        check_scale(global_current_scale, 7'h2A);
    endtask

    // Duty frame, then the first two segments
    task automatic sc_duty();
        logic [255:0] frame;
        for (int n = 0; n < NUM_CH; n++) frame[16*n +: 16] = CODES[n];
        u_spwm_host_model.shift(frame, 256);
        u_spwm_host_model.latch(1'b0);
        check_scale(global_current_scale, 7'h2A);
        u_spwm_host_model.set_blank(1'b0);
        run_counts(0, 1023);
    endtask

    // Blanking mid-cycle clears sinks and restarts the count
    task automatic sc_blank();
        u_spwm_host_model.set_blank(1'b1);
        check_sinks(sink_output_n, 16'h0000);
        u_spwm_host_model.set_blank(1'b0);
        run_counts(0, 2);
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sc_scale();
        sc_duty();
        sc_blank();
        final_report();
    end
endmodule

// *** spwm_host_model.sv ***
// Host controller model: drives the serial port, step clock and blanking.
// Assumes clk_sys runs freely and the bench calls these tasks in sequence.
module spwm_host_model
    import spwm_pkg::*;
(
    // Clock
    input  wire logic    clk_sys,
    // Host pins
    output spwm_serial_s serial_in,
    output logic         gray_step_clock,
    output logic         blank
);
    timeunit 1ns;
    timeprecision 1ns;

    // Drive state that the tasks update, shown on the pins continuously
    spwm_serial_s drv_serial;
    logic         drv_step;
    logic         drv_blank;
    assign serial_in       = drv_serial;
    assign gray_step_clock = drv_step;
    assign blank           = drv_blank;

    // Idle pins: blanking asserted until the scale is loaded
    initial begin
        drv_serial = '0;
        drv_step   = 1'b0;
        drv_blank  = 1'b1;
    end

    // Wait a number of system clock edges
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic shift(input logic [255:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            drv_serial.sdata <= bits[i];
            ticks(4);
            drv_serial.sclk <= 1'b1;
            ticks(4);
            drv_serial.sclk <= 1'b0;
            ticks(4);
        end
        // Released data line shows the inverse of the last bit
        drv_serial.sdata <= ~drv_serial.sdata;
    endtask

    // Latch pulse with the select level held around it
    task automatic latch(input logic sel);
        drv_serial.bc_sel <= sel;
        ticks(4);
        drv_serial.latch <= 1'b1;
        ticks(4);
        drv_serial.latch <= 1'b0;
        ticks(4);
    endtask

    // both scale latches loaded before outputs are enabled
    task automatic load_scale(input logic [SCALE_W-1:0] s);
        shift({249'h0, s}, 7);
        latch(1'b1);
        drv_blank <= 1'b1;
        ticks(4);
    endtask

    // Blanking level, held long enough to be seen
    task automatic set_blank(input logic v);
        drv_blank <= v;
        ticks(4);
    endtask

    // One step clock period, three clocks high and three low
    task automatic step();
        drv_step <= 1'b1;
        ticks(3);
        drv_step <= 1'b0;
        ticks(3);
    endtask
endmodule

// *** spwm_pkg.sv ***
// Shared constants and types for the scrambled PWM sink driver core.
// Assumes a single system clock; all host pins arrive asynchronously.
package spwm_pkg;
    localparam int unsigned NUM_CH    = 16;   // Sink outputs
    localparam int unsigned DUTY_W    = 16;   // Per-channel duty code width
    localparam int unsigned SCALE_W   = 7;    // Global current scale width
    localparam int unsigned SEG_W     = 7;    // Segment index width, 128 segments
    localparam int unsigned POS_W     = 9;    // Position in segment, 512 periods
    localparam int unsigned SREG_W    = NUM_CH * DUTY_W;
    localparam int unsigned PIN_W     = 6;    // Number of synchronised pins

    localparam logic [SCALE_W-1:0] SCALE_FULL  = 7'h7F;     // Full-scale current code
    localparam logic [DUTY_W-1:0]  CYCLE_LAST  = 16'hFFFF;  // Last count of a display cycle
    localparam logic [DUTY_W-1:0]  CYCLE_FIRST = 16'h0000;  // Count at the first edge

    // Reset values of the pin synchronisers: blanking reads as asserted
    localparam logic [PIN_W-1:0]   PIN_RESET   = 6'h20;

    // Bit positions inside the synchronised pin vector
    localparam int unsigned PB_SDATA = 0;
    localparam int unsigned PB_SCLK  = 1;
    localparam int unsigned PB_LATCH = 2;
    localparam int unsigned PB_BCSEL = 3;
    localparam int unsigned PB_GCLK  = 4;
    localparam int unsigned PB_BLANK = 5;

    // Host-facing serial port pins
    typedef struct packed {
        logic bc_sel;   // High: latch pulse loads the current scale
        logic latch;    // Rising edge transfers the shift register
        logic sclk;     // Rising edge shifts in one bit
        logic sdata;    // Serial data, MSB first
    } spwm_serial_s;

    // Display-cycle counter state
    typedef struct packed {
        logic              running;
        logic [DUTY_W-1:0] cnt;
    } spwm_count_s;
endpackage
